// >>> rdioc_ext_ctrl.sv
`timescale 1ns/1ps
// ----
// far-side controller driving the command lines
// ----
module rdioc_ext_ctrl
(
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [7:0] pat_i,
    input wire logic [15:0] hold_i,
    output logic [7:0] pin_o
);
    logic [15:0] left_r = 16'h0;
    logic [7:0] pat_r = 8'h00;
    // a request loads pattern and hold time; short holds break the minimum
    always_ff @(posedge clk_i)
    begin
        if (req_i)
            {left_r, pat_r} <= {hold_i, pat_i};
        else if (left_r != 16'h0)
            left_r <= left_r - 16'h1;
    end
    // released lines sit at the pull-down level
    assign pin_o = (left_r != 16'h0) ? pat_r : 8'h00;
endmodule // rdioc_ext_ctrl

// >>> rdioc_filter.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// input synchroniser and qualification filter, one per line
// ------------------------------------------------------------
module rdioc_filter
#(
    parameter int unsigned QUAL_CYC = rdioc_pkg::RDIOC_QUAL_CYC
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic pin_i,
    output logic level_o
);
    import rdioc_pkg::*;

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic [RDIOC_CNT_W-1:0] cnt_r;

    // three stages; only s2 and s3 are looked at downstream
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end
        else
        begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a high only counts once it persisted the whole interval; a low held two
    // cycles restarts the count, a one-cycle glitch from relay bounce only holds it
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_r <= RDIOC_CNT_ZERO;
            level_o <= 1'b0;
        end
        else if (s2_r && s3_r)
        begin
            if (cnt_r >= QUAL_CYC[RDIOC_CNT_W-1:0] - RDIOC_CNT_ONE)
                level_o <= 1'b1;
            else
                cnt_r <= cnt_r + RDIOC_CNT_ONE;
        end
        else if (!s2_r && !s3_r)
        begin
            cnt_r <= RDIOC_CNT_ZERO;
            level_o <= 1'b0;
        end
    end
endmodule // rdioc_filter

// >>> rdioc_pkg.sv
package rdioc_pkg;
// Overview of operation
// - ready output high while remote mode enabled and system is in standby; the code gates it with dio_en_i, not din_en_i
// - ready drops on start, stays low until after stop, returns in standby
// - start and stop each give a high pulse of about 200 ms on own line
// - status-change line goes high with every start or stop pulse
// - ready, start, stop and status stay low unless remote mode enabled; the code gates them with dio_en_i, not din_en_i
// - remote-mode line high for as long as digital input enable is set
// - level input high runs the test, low level stops it
// - eight pattern inputs evaluated only while digital input enable is set
// - each command has eight-bit mask, bit 7 is the highest input line
// - a mask with several ones needs all marked inputs high together
// - detected pattern executes its command: start, stop, pause or continue
// - an indefinite schedule pause holds drive until a continue arrives
// - continue during a schedule pause resumes vibration at once
// - decoded start begins a test just as a local start would
// - decoded continue out of a pause advances the schedule to its next entry

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned RDIOC_CLK_HZ = 40000000;
    localparam int unsigned RDIOC_PULSE_MS = 200;
    localparam int unsigned RDIOC_QUAL_MS = 200;
    // longest time: round down
    localparam int unsigned RDIOC_PULSE_CYC =
        RDIOC_CLK_HZ / 1000 * RDIOC_PULSE_MS;
    // least time: round up
    localparam int unsigned RDIOC_QUAL_CYC =
        (RDIOC_CLK_HZ / 1000 * RDIOC_QUAL_MS + 999) / 1000 * 1000;
    localparam int unsigned RDIOC_CNT_W = 24;

    // ------------------------------------------------------------
    // pattern inputs and commands
    // ------------------------------------------------------------
    localparam int unsigned RDIOC_NIN = 8;
    localparam logic [7:0] RDIOC_MASK_RST = 8'h00;
    localparam logic [RDIOC_CNT_W-1:0] RDIOC_CNT_ZERO = 24'h000000;
    localparam logic [RDIOC_CNT_W-1:0] RDIOC_CNT_ONE = 24'h000001;

    // test sequencing states
    typedef enum logic [2:0]
    {
        RDIOC_ST_IDLE,
        RDIOC_ST_RUN,
        RDIOC_ST_PAUSE,
        RDIOC_ST_STOPPING
    } rdioc_state_type;
endpackage

// >>> rdioc_port.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// remote digital i/o control port
// ------------------------------------------------------------
module rdioc_port
#(
    parameter int unsigned PULSE_CYC = rdioc_pkg::RDIOC_PULSE_CYC,
    parameter int unsigned QUAL_CYC = rdioc_pkg::RDIOC_QUAL_CYC
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic dio_en_i,
    input wire logic din_en_i,
    input wire logic [7:0] start_mask_i,
    input wire logic [7:0] stop_mask_i,
    input wire logic [7:0] pause_mask_i,
    input wire logic [7:0] cont_mask_i,
    input wire logic level_run_pin_i,
    input wire logic [rdioc_pkg::RDIOC_NIN-1:0] cmd_pin_i,
    input wire logic local_start_i,
    input wire logic local_stop_i,
    input wire logic sched_pause_i,
    input wire logic test_done_i,
    input wire logic standby_i,
    output logic ready_o,
    output logic start_pulse_o,
    output logic stop_pulse_o,
    output logic status_chg_o,
    output logic remote_mode_o,
    output logic drive_on_o,
    output logic paused_o,
    output logic sched_adv_o,
    output logic [rdioc_pkg::RDIOC_NIN-1:0] din_level_o
);
    import rdioc_pkg::*;

    rdioc_state_type state_r;
    logic lvl_q;
    logic lvl_prev_r;
    logic [RDIOC_NIN-1:0] cmd_q;
    logic [3:0] hit_prev_r;
    logic [3:0] hit;
    logic [3:0] fire;
    logic lvl_rise;
    logic lvl_fall;
    logic do_start;
    logic do_stop;
    logic do_pause;
    logic do_cont;
    logic [RDIOC_CNT_W-1:0] st_cnt_r;
    logic [RDIOC_CNT_W-1:0] sp_cnt_r;

    // ------------------------------------------------------------
    // input qualification
    // ------------------------------------------------------------
    rdioc_filter #(.QUAL_CYC(QUAL_CYC)) u_lvl
    (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(level_run_pin_i),
        .level_o(lvl_q)
    );

    // one filter per pattern line
    genvar gi;
    generate
        for (gi = 0; gi < RDIOC_NIN; gi++)
        begin : g_in
            rdioc_filter #(.QUAL_CYC(QUAL_CYC)) u_f
            (
                .clk_i(clk_i),
                .arst_n_i(arst_n_i),
                .pin_i(cmd_pin_i[gi]),
                .level_o(cmd_q[gi])
            );
        end
    endgenerate

    assign din_level_o = cmd_q;

    // ------------------------------------------------------------
    // pattern decode
    // ------------------------------------------------------------
    // all marked lines must be high together; an empty mask never fires,
    // so an unconfigured command stays dormant after reset
    function automatic logic match(input logic [7:0] m,
                                   input logic [7:0] v);
        match = (m != RDIOC_MASK_RST) && ((v & m) == m);
    endfunction

    // decode gated by the input enable
    always_comb
    begin
        hit[0] = din_en_i && match(start_mask_i, cmd_q);
        hit[1] = din_en_i && match(stop_mask_i, cmd_q);
        hit[2] = din_en_i && match(pause_mask_i, cmd_q);
        hit[3] = din_en_i && match(cont_mask_i, cmd_q);
    end

    // rising edge of a match: fires once per assertion
    assign fire = hit & ~hit_prev_r;
    assign lvl_rise = lvl_q && !lvl_prev_r;
    assign lvl_fall = !lvl_q && lvl_prev_r;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            hit_prev_r <= 4'h0;
            lvl_prev_r <= 1'b0;
        end
        else
        begin
            hit_prev_r <= hit;
            lvl_prev_r <= lvl_q;
        end
    end

    // stop takes priority over start when both arrive together
    assign do_stop = fire[1] || lvl_fall || local_stop_i;
    assign do_start = !do_stop
        && (fire[0] || lvl_rise || local_start_i);
    assign do_pause = fire[2];
    assign do_cont = fire[3];

    // ------------------------------------------------------------
    // test sequencing
    // ------------------------------------------------------------
    // stopping lingers until the system reports standby, so ready is
    // only raised once the drive has really wound down
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state_r <= RDIOC_ST_IDLE;
        else
        begin
            case (state_r)
                RDIOC_ST_IDLE:
                    if (do_start && standby_i)
                        state_r <= RDIOC_ST_RUN;
                RDIOC_ST_RUN:
                    if (do_stop || test_done_i)
                        state_r <= RDIOC_ST_STOPPING;
                    else if (do_pause || sched_pause_i)
                        state_r <= RDIOC_ST_PAUSE;
                RDIOC_ST_PAUSE:
                    if (do_stop)
                        state_r <= RDIOC_ST_STOPPING;
                    else if (do_cont)
                        state_r <= RDIOC_ST_RUN;
                RDIOC_ST_STOPPING:
                    if (standby_i)
                        state_r <= RDIOC_ST_IDLE;
                default:
                    state_r <= RDIOC_ST_IDLE;
            endcase
        end
    end

    // schedule advance pulse on a continue out of a pause
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            sched_adv_o <= 1'b0;
        else
            sched_adv_o <= (state_r == RDIOC_ST_PAUSE)
                && do_cont && !do_stop;
    end

    // drive follows the state with no extra delay
    assign drive_on_o = (state_r == RDIOC_ST_RUN);
    assign paused_o = (state_r == RDIOC_ST_PAUSE);

    // ------------------------------------------------------------
    // status pulses
    // ------------------------------------------------------------
    // counters run in any mode; outputs are masked by the enable below
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_cnt_r <= RDIOC_CNT_ZERO;
            sp_cnt_r <= RDIOC_CNT_ZERO;
        end
        else
        begin
            if (state_r == RDIOC_ST_IDLE && do_start && standby_i)
                st_cnt_r <= PULSE_CYC[RDIOC_CNT_W-1:0];
            else if (st_cnt_r != RDIOC_CNT_ZERO)
                st_cnt_r <= st_cnt_r - RDIOC_CNT_ONE;
            if ((state_r == RDIOC_ST_RUN || state_r == RDIOC_ST_PAUSE)
                && (do_stop || (test_done_i && state_r == RDIOC_ST_RUN)))
                sp_cnt_r <= PULSE_CYC[RDIOC_CNT_W-1:0];
            else if (sp_cnt_r != RDIOC_CNT_ZERO)
                sp_cnt_r <= sp_cnt_r - RDIOC_CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ready_o <= 1'b0;
            start_pulse_o <= 1'b0;
            stop_pulse_o <= 1'b0;
            status_chg_o <= 1'b0;
            remote_mode_o <= 1'b0;
        end
        else
        begin
            ready_o <= dio_en_i && (state_r == RDIOC_ST_IDLE)
                && standby_i;
            start_pulse_o <= dio_en_i
                && (st_cnt_r != RDIOC_CNT_ZERO);
            stop_pulse_o <= dio_en_i
                && (sp_cnt_r != RDIOC_CNT_ZERO);
            status_chg_o <= dio_en_i && ((st_cnt_r != RDIOC_CNT_ZERO)
                || (sp_cnt_r != RDIOC_CNT_ZERO));
            remote_mode_o <= din_en_i;
        end
    end
endmodule // rdioc_port

// >>> rdioc_port_assertions.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module rdioc_port_assertions
#(
    parameter int unsigned PULSE_CYC = 20,
    parameter int unsigned QUAL_CYC = 10
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic dio_en_i,
    input wire logic din_en_i,
    input wire logic standby_i,
    input wire logic [7:0] cmd_pin_i,
    input wire logic ready_o,
    input wire logic start_pulse_o,
    input wire logic stop_pulse_o,
    input wire logic status_chg_o,
    input wire logic remote_mode_o,
    input wire logic drive_on_o,
    input wire logic paused_o,
    input wire logic sched_adv_o,
    input wire logic [7:0] din_level_o
);
    logic [31:0] st_len_r;
    logic [31:0] sp_len_r;
    // pulses outlast the repetition limit, so count them instead
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            {st_len_r, sp_len_r} <= 64'h0;
        else
            {st_len_r, sp_len_r} <= {start_pulse_o ? st_len_r + 32'h1 : 32'h0,
                stop_pulse_o ? sp_len_r + 32'h1 : 32'h0};
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // outputs against their causes
    AST_START_LEN: assert property ($fell(start_pulse_o) |->
        st_len_r == PULSE_CYC) else $error("start pulse length");
    AST_STOP_LEN: assert property ($fell(stop_pulse_o) |->
        sp_len_r == PULSE_CYC) else $error("stop pulse length");
    AST_STATUS: assert property (
        (start_pulse_o || stop_pulse_o) |-> status_chg_o)
        else $error("status line low");
    AST_READY_DROP: assert property ($rose(start_pulse_o) |->
        !ready_o) else $error("ready high at start");
    AST_READY_RISE: assert property ($rose(ready_o) |->
        $past(dio_en_i) && $past(standby_i)) else $error("ready rise");
    AST_GATE: assert property (!dio_en_i && !$past(dio_en_i) |->
        !(ready_o || start_pulse_o || stop_pulse_o || status_chg_o))
        else $error("output while disabled");
    AST_MODE: assert property ($past(arst_n_i) |->
        remote_mode_o == $past(din_en_i)) else $error("remote mode");
    // a line only qualifies if it was already high one filter time back
    AST_FILTER: assert property (
        (din_level_o & ~$past(din_level_o) &
        ~$past(cmd_pin_i, QUAL_CYC)) == 8'h00) else $error("short high passed");
    AST_ADV: assert property ($rose(sched_adv_o) |->
        ($past(paused_o) && drive_on_o) ##1 !sched_adv_o) else $error("adv");
    AST_PAUSE_EXIT: assert property ($fell(paused_o) &&
        drive_on_o |-> sched_adv_o) else $error("left pause without continue");
    cover property ($rose(sched_adv_o));
    cover property ($rose(drive_on_o));
    cover property ($fell(stop_pulse_o));
    cover property ($rose(paused_o));
endmodule // rdioc_port_assertions

bind rdioc_port rdioc_port_assertions
    #(.PULSE_CYC(PULSE_CYC), .QUAL_CYC(QUAL_CYC)) u_chk (.*);

// >>> testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
num_errors++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
// ----
// bench top
// ----
module testbench;
    logic clk_i = 1'h0, arst_n_i = 1'h0, dio_en_i = 1'h0, din_en_i = 1'h0;
    logic standby_i = 1'h0, level_run_pin_i = 1'h0, local_start_i = 1'h0;
    logic local_stop_i = 1'h0, sched_pause_i = 1'h0, test_done_i = 1'h0;
    logic [7:0] start_mask_i = 8'h00, stop_mask_i = 8'h00;
    logic [7:0] pause_mask_i = 8'h00, cont_mask_i = 8'h00, pat = 8'h00;
    logic [7:0] cmd_pin_i, din_level_o;
    logic [15:0] hold = 16'h0;
    logic req = 1'h0, ready_o, start_pulse_o, stop_pulse_o, status_chg_o;
    logic remote_mode_o, drive_on_o, paused_o, sched_adv_o;
    int num_errors = 0, comparisons = 0;
    wire [5:0] mon = {drive_on_o, ready_o, sched_adv_o, paused_o,
        stop_pulse_o, start_pulse_o};
    // short counts keep the run brief
    rdioc_port #(.PULSE_CYC(20), .QUAL_CYC(10)) DUT (.*);
    rdioc_ext_ctrl u_ext (.clk_i(clk_i), .req_i(req), .pat_i(pat),
        .hold_i(hold), .pin_o(cmd_pin_i));
    always #12.5 clk_i = ~clk_i;
    // ----
    // shared tasks
    // ----
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic send(input logic [7:0] p, input logic [15:0] h);
        {pat, hold, req} = {p, h, 1'h1};
        tick(1);
        req = 1'h0;
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // bounded wait; running out ends the run
    task automatic wait_for(input int k, input logic v);
        int n = 0;
        while (mon[k] !== v && n < 80)
        begin
            tick(1);
            n++;
        end
        `CHK("wait", v, mon[k])
        if (n == 80)
            print_verdict();
    endtask
    // ----
    // scenarios
    // ----
    task automatic sc_setup();
        logic [15:0] seen;
        seen = {mon, status_chg_o, remote_mode_o, din_level_o};
        `CHK("rst", 16'h0, seen)
        {start_mask_i, stop_mask_i, pause_mask_i, cont_mask_i} = 32'h01020c10;
        {dio_en_i, din_en_i, standby_i} = 3'h7;
        tick(2);
        `CHK("mode", 2'h3, {remote_mode_o, ready_o})
        send(8'h01, 16'h3);
        tick(30);
        `CHK("glitch", 1'h0, drive_on_o)
    endtask
    task automatic sc_start();
        int n = 0;
        send(8'h01, 16'h20);
        wait_for(0, 1'h1);
        `CHK("run", 3'h3, {ready_o, status_chg_o, drive_on_o})
        while (start_pulse_o === 1'h1 && n < 40)
        begin
            tick(1);
            n++;
        end
        `CHK("len", 20, n)
    endtask
    task automatic sc_pause();
        send(8'h04, 16'h20);
        tick(40);
        `CHK("part", 1'h0, paused_o)
        send(8'h0c, 16'h20);
        wait_for(2, 1'h1);
        tick(40);
        `CHK("hold", 1'h1, paused_o)
        send(8'h10, 16'h20);
        wait_for(3, 1'h1);
        `CHK("resume", 1'h1, drive_on_o)
        tick(40);
        sched_pause_i = 1'h1;
        tick(1);
        sched_pause_i = 1'h0;
        wait_for(2, 1'h1);
        send(8'h10, 16'h20);
        wait_for(3, 1'h1);
    endtask
    task automatic sc_stop();
        tick(40);
        send(8'h02, 16'h20);
        wait_for(1, 1'h1);
        `CHK("chg", 2'h1, {drive_on_o, status_chg_o})
        wait_for(4, 1'h1);
    endtask
    task automatic sc_gates();
        logic [4:0] seen;
        din_en_i = 1'h0;
        send(8'h01, 16'h20);
        tick(40);
        `CHK("din", 2'h0, {remote_mode_o, drive_on_o})
        {din_en_i, dio_en_i, local_start_i} = 3'h5;
        tick(1);
        local_start_i = 1'h0;
        tick(3);
        seen = {mon[1:0], ready_o, status_chg_o, drive_on_o};
        `CHK("dio", 5'h1, seen)
        local_stop_i = 1'h1;
        tick(1);
        local_stop_i = 1'h0;
        tick(3);
        `CHK("dio2", 2'h0, {stop_pulse_o, drive_on_o})
        // let the hidden pulses run out so no stub appears on enable
        tick(25);
        dio_en_i = 1'h1;
    endtask
    task automatic sc_level();
        tick(4);
        level_run_pin_i = 1'h1;
        wait_for(5, 1'h1);
        tick(40);
        `CHK("lvl", 1'h1, drive_on_o)
        level_run_pin_i = 1'h0;
        wait_for(5, 1'h0);
    endtask
    // end of schedule acts as a stop while running
    task automatic sc_done();
        tick(30);
        local_start_i = 1'h1;
        tick(1);
        local_start_i = 1'h0;
        wait_for(5, 1'h1);
        test_done_i = 1'h1;
        tick(1);
        test_done_i = 1'h0;
        wait_for(1, 1'h1);
        `CHK("done", 1'h0, drive_on_o)
        wait_for(4, 1'h1);
    endtask
    initial
    begin
        tick(4);
        arst_n_i = 1'h1;
        tick(1);
        sc_setup();
        sc_start();
        sc_pause();
        sc_stop();
        sc_gates();
        sc_level();
        sc_done();
        print_verdict();
    end
endmodule // testbench
